// file: rtl/icdma_consts.svh
// offsets, field values and timing counts of the isa compatible dma block
`ifndef ICDMA_CONSTS_SVH
`define ICDMA_CONSTS_SVH
`define ICDMA_OFF_REQ 8'h80
`define ICDMA_OFF_MASK 8'h84
`define ICDMA_OFF_STATUS 8'h88
`define ICDMA_OFF_REFRESH 8'h8C
`define ICDMA_SUB_ADDR 4'h0
`define ICDMA_SUB_COUNT 4'h4
`define ICDMA_SUB_PAGE 4'h8
`define ICDMA_SUB_MODE 4'hC
`define ICDMA_MODE_RESET 8'h00
`define ICDMA_MODE_CASC_RESET 8'hC0
`define ICDMA_MASK_RESET 8'hEF
`define ICDMA_SEL_DEMAND 2'h0
`define ICDMA_SEL_SINGLE 2'h1
`define ICDMA_SEL_BLOCK 2'h2
`define ICDMA_SEL_CASCADE 2'h3
`define ICDMA_XFER_VERIFY 2'h0
`define ICDMA_XFER_TO_MEM 2'h1
`define ICDMA_XFER_FROM_MEM 2'h2
`define ICDMA_CASC_CH 3'h4
`define ICDMA_FIRST_WIDE_CH 3'h5
`define ICDMA_CLK_NS 10
`define ICDMA_STROBE_NS 120
`define ICDMA_STROBE_CYC ((`ICDMA_STROBE_NS + `ICDMA_CLK_NS - 1) / `ICDMA_CLK_NS)
`endif

// file: rtl/icdma_pkg.sv
// types shared by the isa compatible dma block
package icdma_pkg;
  typedef struct packed {
    logic [1:0] sel;
    logic dec;
    logic auto_init;
    logic [1:0] xfer;
    logic [1:0] rsvd;
  } icdma_mode_type;

  typedef struct packed {
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic mem_read_strobe_n;
    logic mem_write_strobe_n;
    logic low_mem_read_strobe_n;
    logic low_mem_write_strobe_n;
  } icdma_strobe_type;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_XFER, ST_CASCADE, ST_REFRESH} icdma_state_type;
endpackage : icdma_pkg

// file: rtl/icdma_arb.sv
// fixed priority pick of the lowest numbered requesting channel
module icdma_arb
(
  input wire logic [7:0] req,
  output logic valid,
  output logic [2:0] idx
);
  // =========================================
  // priority decode
  function automatic logic [2:0] lowest_set(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
        r = 3'(i);
    end
    return r;
  endfunction : lowest_set

  // channel 4 sits between 3 and 5, so the cascade ranks at its own slot
  assign valid = |req;
  assign idx = lowest_set(req);
endmodule : icdma_arb

// file: rtl/icdma_top.sv
// isa compatible dma controller with ahb-lite register access
//
// Chosen here: the register offsets and the AHB-Lite register port.
`include "icdma_consts.svh"

// Notes on behaviour
// - seven programmable channels, 0-3 primary unit, 5-7 secondary unit.
// - channel 4 links the units, resets to cascade mode, nothing else.
// - hardware request lines from slave devices are accepted.
// - writing a one to a request register bit starts that channel; here only while that channel's mask bit is clear.
// - channels 0-3 move bytes, address and count step by one byte.
// - channels 5-7 move words; word address is shifted onto the bus.
// - each channel forms a 32-bit address, bits 15:0 from current register (16:1 on word channels); 24 bits reach the pins.
// - the page register supplies address bits 31:16, bits 31:17 on word channels.
// - refresh addresses are generated.
// - at terminal count an auto-init channel reloads its start values.
// - always exactly master or slave; master serves a request or a cascade.
// - in slave mode the block decodes and answers its register accesses.
// - strobe timing and byte or word width control for every transfer.
// - below 16 Mbytes the memory read or write strobe is driven.
// - below 1 Mbyte the low memory strobes are driven too.
// - at or above 16 Mbytes the memory strobes are suppressed.
module icdma_top
  import icdma_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [7:0] dreq,
  input wire logic refresh_req,
  output logic [7:0] dack,
  output logic [23:0] dma_addr,
  output icdma_strobe_type strobes,
  output logic byte_high_en_n,
  output logic aen,
  output logic terminal_count,
  output logic master_mode
);
  // =========================================
  // functions
  function automatic logic [31:0] chan_addr(input logic [2:0] ch, input logic [15:0] cur,
                                            input logic [15:0] page);
    if (ch >= `ICDMA_FIRST_WIDE_CH)
      return {page[15:1], cur, 1'b0};
    return {page, cur};
  endfunction : chan_addr

  function automatic logic below_16m(input logic [31:0] a);
    return a[31:24] == 8'h00;
  endfunction : below_16m

  // =========================================
  // input synchronisers
  logic [7:0] dreq_meta_reg, dreq_sync_reg;
  logic [2:0] refresh_sync_reg;
  logic refresh_rise;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dreq_meta_reg <= 8'h00;
      dreq_sync_reg <= 8'h00;
      refresh_sync_reg <= 3'h0;
    end
    else
    begin
      dreq_meta_reg <= dreq;
      dreq_sync_reg <= dreq_meta_reg;
      refresh_sync_reg <= {refresh_sync_reg[1:0], refresh_req};
    end
  end

  assign refresh_rise = refresh_sync_reg[1] & ~refresh_sync_reg[2];

  // =========================================
  // declarations
  logic [15:0] base_addr_reg[8], base_addr_next[8];
  logic [15:0] cur_addr_reg[8], cur_addr_next[8];
  logic [15:0] base_count_reg[8], base_count_next[8];
  logic [15:0] cur_count_reg[8], cur_count_next[8];
  logic [15:0] page_reg[8], page_next[8];
  icdma_mode_type mode_reg[8], mode_next[8];
  logic [7:0] sw_req_reg, sw_req_next, mask_reg, mask_next, tc_status_reg, tc_status_next;
  logic refresh_pend_reg, refresh_pend_next;
  logic [15:0] refresh_addr_reg, refresh_addr_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  icdma_state_type state_reg, state_next;
  logic [2:0] act_reg, act_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [31:0] xfer_addr_reg, xfer_addr_next;
  icdma_strobe_type strobes_reg, strobes_next;
  logic [7:0] dack_reg, dack_next;
  logic bhe_n_reg, bhe_n_next, aen_reg, aen_next, tc_reg, tc_next, master_reg, master_next;
  logic addr_phase, status_rd, wr_chan, step_done, act_tc, arb_valid;
  logic [2:0] arb_idx, wr_ch;
  logic [7:0] eff_req;
  logic [31:0] rd_word;

  // =========================================
  // ahb-lite slave
  // zero wait states; read data is fetched in the address phase
  assign addr_phase = hsel & htrans[1] & hready;
  assign status_rd = addr_phase & ~hwrite & (haddr == {24'h000000, `ICDMA_OFF_STATUS});
  assign wr_chan = wr_pend_reg & ~wr_addr_reg[7];
  assign wr_ch = wr_addr_reg[6:4];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_comb
  begin
    rd_word = 32'h00000000;
    if (haddr[31:8] == 24'h000000 && !haddr[7])
    begin
      unique case (haddr[3:0])
        `ICDMA_SUB_ADDR: rd_word = {16'h0000, cur_addr_reg[haddr[6:4]]};
        `ICDMA_SUB_COUNT: rd_word = {16'h0000, cur_count_reg[haddr[6:4]]};
        `ICDMA_SUB_PAGE: rd_word = {16'h0000, page_reg[haddr[6:4]]};
        `ICDMA_SUB_MODE: rd_word = {24'h000000, mode_reg[haddr[6:4]]};
        default: rd_word = 32'h00000000;
      endcase
    end
    else if (haddr[31:8] == 24'h000000)
    begin
      unique case (haddr[7:0])
        `ICDMA_OFF_REQ: rd_word = {24'h000000, sw_req_reg};
        `ICDMA_OFF_MASK: rd_word = {24'h000000, mask_reg};
        `ICDMA_OFF_STATUS: rd_word = {15'h0000, master_reg, eff_req, tc_status_reg};
        `ICDMA_OFF_REFRESH: rd_word = {16'h0000, refresh_addr_reg};
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  always_comb
  begin
    wr_pend_next = addr_phase & hwrite;
    wr_addr_next = addr_phase ? haddr[7:0] : wr_addr_reg;
    if (haddr[31:8] != 24'h000000)
      wr_pend_next = 1'b0;
    hrdata_next = (addr_phase & ~hwrite) ? rd_word : hrdata_reg;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end
    else
    begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // =========================================
  // channel registers
  assign step_done = (state_reg == ST_XFER) && (cnt_reg == 4'h0);
  assign act_tc = cur_count_reg[act_reg] == 16'h0000;

  always_comb
  begin
    base_addr_next = base_addr_reg;
    cur_addr_next = cur_addr_reg;
    base_count_next = base_count_reg;
    cur_count_next = cur_count_reg;
    page_next = page_reg;
    mode_next = mode_reg;
    if (step_done)
    begin
      // word channels step the word address by one, shifted later
      cur_addr_next[act_reg] = mode_reg[act_reg].dec ? cur_addr_reg[act_reg] - 16'h0001
                                                     : cur_addr_reg[act_reg] + 16'h0001;
      cur_count_next[act_reg] = cur_count_reg[act_reg] - 16'h0001;
      if (act_tc && mode_reg[act_reg].auto_init)
      begin
        cur_addr_next[act_reg] = base_addr_reg[act_reg];
        cur_count_next[act_reg] = base_count_reg[act_reg];
      end
    end
    if (wr_chan)
    begin
      unique case (wr_addr_reg[3:0])
        `ICDMA_SUB_ADDR:
        begin
          base_addr_next[wr_ch] = hwdata[15:0];
          cur_addr_next[wr_ch] = hwdata[15:0];
        end
        `ICDMA_SUB_COUNT:
        begin
          base_count_next[wr_ch] = hwdata[15:0];
          cur_count_next[wr_ch] = hwdata[15:0];
        end
        `ICDMA_SUB_PAGE: page_next[wr_ch] = hwdata[15:0];
        `ICDMA_SUB_MODE: mode_next[wr_ch] = hwdata[7:0];
        default: ;
      endcase
    end
    mode_next[`ICDMA_CASC_CH].sel = `ICDMA_SEL_CASCADE;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < 8; i++)
      begin
        base_addr_reg[i] <= 16'h0000;
        cur_addr_reg[i] <= 16'h0000;
        base_count_reg[i] <= 16'h0000;
        cur_count_reg[i] <= 16'h0000;
        page_reg[i] <= 16'h0000;
        mode_reg[i] <= (i == 4) ? `ICDMA_MODE_CASC_RESET : `ICDMA_MODE_RESET;
      end
    end
    else
    begin
      base_addr_reg <= base_addr_next;
      cur_addr_reg <= cur_addr_next;
      base_count_reg <= base_count_next;
      cur_count_reg <= cur_count_next;
      page_reg <= page_next;
      mode_reg <= mode_next;
    end
  end

  // =========================================
  // global control and status
  // a set in the same cycle as a clear always wins
  always_comb
  begin
    sw_req_next = sw_req_reg;
    mask_next = mask_reg;
    tc_status_next = status_rd ? 8'h00 : tc_status_reg;
    refresh_pend_next = (state_next == ST_REFRESH) ? 1'b0 : refresh_pend_reg;
    refresh_addr_next = refresh_addr_reg;
    if (step_done && act_tc)
    begin
      sw_req_next[act_reg] = 1'b0;
      tc_status_next[act_reg] = 1'b1;
    end
    if (state_reg == ST_REFRESH && cnt_reg == 4'h0)
      refresh_addr_next = refresh_addr_reg + 16'h0001;
    if (wr_pend_reg && wr_addr_reg == `ICDMA_OFF_REQ)
      sw_req_next = sw_req_next | hwdata[7:0];
    if (wr_pend_reg && wr_addr_reg == `ICDMA_OFF_MASK)
      mask_next = hwdata[7:0];
    if (wr_pend_reg && wr_addr_reg == `ICDMA_OFF_REFRESH)
      refresh_addr_next = hwdata[15:0];
    if (refresh_rise)
      refresh_pend_next = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sw_req_reg <= 8'h00;
      mask_reg <= `ICDMA_MASK_RESET;
      tc_status_reg <= 8'h00;
      refresh_pend_reg <= 1'b0;
      refresh_addr_reg <= 16'h0000;
    end
    else
    begin
      sw_req_reg <= sw_req_next;
      mask_reg <= mask_next;
      tc_status_reg <= tc_status_next;
      refresh_pend_reg <= refresh_pend_next;
      refresh_addr_reg <= refresh_addr_next;
    end
  end

  // =========================================
  // arbitration and transfer sequencing
  assign eff_req = (dreq_sync_reg | sw_req_reg) & ~mask_reg;

  icdma_arb arb_u
  (
    .req(eff_req),
    .valid(arb_valid),
    .idx(arb_idx)
  );

  always_comb
  begin
    state_next = state_reg;
    act_next = act_reg;
    cnt_next = (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : 4'h0;
    unique case (state_reg)
      ST_IDLE:
      begin
        // refresh goes first from idle; a block or demand run keeps the bus until it ends
        if (refresh_pend_reg)
        begin
          state_next = ST_REFRESH;
          cnt_next = 4'(`ICDMA_STROBE_CYC - 1);
        end
        else if (arb_valid)
        begin
          act_next = arb_idx;
          state_next = (mode_reg[arb_idx].sel == `ICDMA_SEL_CASCADE) ? ST_CASCADE : ST_ADDR;
        end
      end
      ST_ADDR:
      begin
        state_next = ST_XFER;
        cnt_next = 4'(`ICDMA_STROBE_CYC - 1);
      end
      ST_XFER:
      begin
        if (cnt_reg == 4'h0)
        begin
          state_next = ST_IDLE;
          if (!act_tc && mode_reg[act_reg].sel == `ICDMA_SEL_BLOCK)
            state_next = ST_ADDR;
          if (!act_tc && mode_reg[act_reg].sel == `ICDMA_SEL_DEMAND && eff_req[act_reg])
            state_next = ST_ADDR;
        end
      end
      ST_CASCADE:
      begin
        if (!eff_req[act_reg])
          state_next = ST_IDLE;
      end
      ST_REFRESH:
      begin
        if (cnt_reg == 4'h0)
          state_next = ST_IDLE;
      end
    endcase
  end

  always_comb
  begin
    xfer_addr_next = chan_addr(act_next, cur_addr_next[act_next], page_reg[act_next]);
    strobes_next = '1;
    dack_next = 8'h00;
    aen_next = 1'b0;
    bhe_n_next = 1'b1;
    tc_next = 1'b0;
    master_next = state_next != ST_IDLE;
    if (state_next == ST_REFRESH)
    begin
      xfer_addr_next = {16'h0000, refresh_addr_reg};
      aen_next = 1'b1;
      strobes_next.mem_read_strobe_n = 1'b0;
      strobes_next.low_mem_read_strobe_n = 1'b0;
    end
    if (state_next == ST_ADDR || state_next == ST_XFER)
    begin
      aen_next = 1'b1;
      dack_next[act_next] = 1'b1;
      bhe_n_next = act_next < `ICDMA_FIRST_WIDE_CH;
    end
    if (state_next == ST_XFER)
    begin
      tc_next = (cnt_next == 4'h0) && (cur_count_reg[act_next] == 16'h0000);
      if (mode_reg[act_next].xfer == `ICDMA_XFER_TO_MEM)
      begin
        strobes_next.io_read_strobe_n = 1'b0;
        strobes_next.mem_write_strobe_n = !below_16m(xfer_addr_next);
        strobes_next.low_mem_write_strobe_n = xfer_addr_next[31:20] != 12'h000;
      end
      if (mode_reg[act_next].xfer == `ICDMA_XFER_FROM_MEM)
      begin
        strobes_next.io_write_strobe_n = 1'b0;
        strobes_next.mem_read_strobe_n = !below_16m(xfer_addr_next);
        strobes_next.low_mem_read_strobe_n = xfer_addr_next[31:20] != 12'h000;
      end
    end
    if (state_next == ST_CASCADE)
      dack_next[act_next] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_IDLE;
      act_reg <= 3'h0;
      cnt_reg <= 4'h0;
      xfer_addr_reg <= 32'h00000000;
      strobes_reg <= '1;
      dack_reg <= 8'h00;
      bhe_n_reg <= 1'b1;
      aen_reg <= 1'b0;
      tc_reg <= 1'b0;
      master_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      act_reg <= act_next;
      cnt_reg <= cnt_next;
      xfer_addr_reg <= xfer_addr_next;
      strobes_reg <= strobes_next;
      dack_reg <= dack_next;
      bhe_n_reg <= bhe_n_next;
      aen_reg <= aen_next;
      tc_reg <= tc_next;
      master_reg <= master_next;
    end
  end

  assign dma_addr = xfer_addr_reg[23:0];
  assign strobes = strobes_reg;
  assign dack = dack_reg;
  assign byte_high_en_n = bhe_n_reg;
  assign aen = aen_reg;
  assign terminal_count = tc_reg;
  assign master_mode = master_reg;

  // =========================================
  // assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence sw_kick_s;
    wr_pend_reg && wr_addr_reg == `ICDMA_OFF_REQ && hwdata[7:0] != 8'h00;
  endsequence
  sequence lone_wait_s;
    state_reg == ST_IDLE && !refresh_pend_reg && (sw_req_reg & ~mask_reg) != 8'h00;
  endsequence

  casc_mode_a: assert property (mode_reg[4].sel == `ICDMA_SEL_CASCADE)
    else $error("channel 4 left cascade mode");
  casc_ack_a: assert property (state_reg == ST_CASCADE |-> dack[act_reg] && act_reg == 3'h4)
    else $error("cascade served by a channel other than 4");
  sw_start_a: assert property (sw_kick_s ##1 lone_wait_s |=> state_reg != ST_IDLE)
    else $error("software request did not start service");
  prio_pick_a: assert property ((state_reg == ST_IDLE && !refresh_pend_reg && arb_valid)
    |=> ($past(eff_req) & ((8'h01 << act_reg) - 8'h01)) == 8'h00)
    else $error("lower channel was passed over");
  width_sel_a: assert property (state_reg == ST_XFER |-> byte_high_en_n == (act_reg < 3'h5))
    else $error("byte high enable wrong for channel width");
  strobe_len_a: assert property ($rose(state_reg == ST_XFER) |-> (state_reg == ST_XFER)[*8])
    else $error("transfer strobe too short");
  mem_drive_a: assert property ((state_reg == ST_XFER && mode_reg[act_reg].xfer == `ICDMA_XFER_TO_MEM
    && xfer_addr_reg[31:24] == 8'h00) |-> !strobes.mem_write_strobe_n)
    else $error("memory write strobe missing below 16M");
  high_quiet_a: assert property (xfer_addr_reg[31:24] != 8'h00
    |-> strobes.mem_read_strobe_n && strobes.mem_write_strobe_n)
    else $error("memory strobe driven at or above 16M");
  low_range_a: assert property ((!strobes.low_mem_read_strobe_n || !strobes.low_mem_write_strobe_n)
    |-> xfer_addr_reg[31:20] == 12'h000)
    else $error("low memory strobe above 1M");
  auto_reload_a: assert property ((step_done && act_tc && mode_reg[act_reg].auto_init)
    |=> cur_count_reg[$past(act_reg)] == base_count_reg[$past(act_reg)])
    else $error("auto init did not reload count");
  refresh_go_a: assert property ((state_reg == ST_IDLE && refresh_pend_reg)
    |=> state_reg == ST_REFRESH && !strobes.mem_read_strobe_n)
    else $error("refresh cycle not issued");
endmodule : icdma_top

// file: test/icdma_isa_dev.sv
// isa side model: slave devices raising requests and one cascaded isa master
module icdma_isa_dev
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [7:0] want,
  input wire logic [7:0] dack,
  output logic [7:0] dreq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] own_cnt;
  // ==========================================
  // request lines
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dreq <= 8'h00;
      own_cnt <= 4'h0;
    end
    else
    begin
      // a slave drops its request once acknowledged, so single mode sees one transfer
      dreq[3:0] <= (dreq[3:0] | want[3:0]) & ~dack[3:0];
      dreq[7:5] <= (dreq[7:5] | want[7:5]) & ~dack[7:5];
      // the isa master keeps the bus for eight cycles, then lets go
      own_cnt <= dack[4] ? own_cnt + 4'h1 : 4'h0;
      dreq[4] <= want[4] | (dreq[4] & (own_cnt != 4'h8));
    end
  end
endmodule : icdma_isa_dev

// file: test/tb_top.sv
// self checking bench of the isa compatible dma block
`include "icdma_consts.svh"
module tb_top
  import icdma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic refresh_req = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] want = 8'h00;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] dreq;
  logic [7:0] dack;
  logic [23:0] dma_addr;
  icdma_strobe_type strobes;
  logic byte_high_en_n;
  logic aen;
  logic terminal_count;
  logic master_mode;
  logic [31:0] rd;
  int err_count = 0;
  int num_checks = 0;

  always #5 hclk = ~hclk;

  icdma_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .dreq(dreq), .refresh_req(refresh_req), .dack(dack),
    .dma_addr(dma_addr), .strobes(strobes), .byte_high_en_n(byte_high_en_n), .aen(aen),
    .terminal_count(terminal_count), .master_mode(master_mode));

  icdma_isa_dev isa_u (.hclk(hclk), .hresetn(hresetn), .want(want), .dack(dack), .dreq(dreq));

  // ==========================================
  // shared tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // hreadyout is fixed high, so the waits end at once; the watchdog covers a stuck bus
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(what, rd, exp);
    chk("hresp", 32'(hresp), 32'h0);
  endtask : rdchk

  task automatic prog(input logic [3:0] ch, input logic [15:0] a, input logic [15:0] pg, input logic [7:0] md);
    ahb(1'b1, {24'h0, ch, `ICDMA_SUB_ADDR}, {16'h0, a});
    ahb(1'b1, {24'h0, ch, `ICDMA_SUB_COUNT}, 32'h0);
    ahb(1'b1, {24'h0, ch, `ICDMA_SUB_PAGE}, {16'h0, pg});
    ahb(1'b1, {24'h0, ch, `ICDMA_SUB_MODE}, {24'h0, md});
  endtask : prog

  task automatic pulse(input logic [7:0] v);
    @(posedge hclk);
    want <= v;
    @(posedge hclk);
    want <= 8'h00;
  endtask : pulse

  // one transfer seen at the pins: address cycle, strobes, terminal count
  task automatic xfer(input int ch, input logic [23:0] ea, input logic bhe, input logic [5:0] st);
    int i;
    logic tc_seen;
    for (i = 0; i < 200 && dack === 8'h00; i++) @(negedge hclk);
    chk("dack", 32'(dack), 32'(8'h01 << ch));
    chk("dma_addr", 32'(dma_addr), 32'(ea));
    chk("bhe", 32'(byte_high_en_n), 32'(bhe));
    chk("aen", 32'(aen), 32'h1);
    chk("master", 32'(master_mode), 32'h1);
    repeat (2) @(negedge hclk);
    chk("strobes", 32'(strobes), 32'(st));
    tc_seen = 1'b0;
    for (i = 0; i < 40 && dack !== 8'h00; i++)
    begin
      tc_seen = tc_seen | terminal_count;
      @(negedge hclk);
    end
    chk("tc", 32'(tc_seen), 32'h1);
  endtask : xfer

  // ==========================================
  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #200us;
    err_count++;
    finish_test();
  end

  // ==========================================
  // tests
  initial
  begin
    int i;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk("mode0", 32'h0C, 32'h00);
    rdchk("mode4", 32'h4C, 32'hC0);
    rdchk("mask", 32'h84, 32'hEF);
    rdchk("request", 32'h80, 32'h0);
    ahb(1'b1, 32'h100, 32'hFF);
    rdchk("unmapped", 32'h100, 32'h0);
    ahb(1'b1, 32'h4C, 32'h04);
    rdchk("mode4 kept", 32'h4C, 32'hC4);
    ahb(1'b1, 32'h84, 32'hC8);
    // hardware request, byte channel, above the low region
    prog(4'h1, 16'h2345, 16'h0012, 8'h44);
    pulse(8'h02);
    xfer(1, 24'h122345, 1'b1, 6'b011011);
    rdchk("cur1", 32'h10, 32'h2346);
    rdchk("cnt1", 32'h14, 32'hFFFF);
    rdchk("status", 32'h88, 32'h2);
    rdchk("status clr", 32'h88, 32'h0);
    // software request, word channel, auto-init; page bit 0 is shifted out
    prog(4'h5, 16'h0400, 16'h0041, 8'h58);
    ahb(1'b1, 32'h80, 32'h20);
    xfer(5, 24'h400800, 1'b0, 6'b100111);
    rdchk("cur5", 32'h50, 32'h0400);
    rdchk("cnt5", 32'h54, 32'h0);
    rdchk("req done", 32'h80, 32'h0);
    // two at once: lowest first; channel 0 sits at 16 Mbytes
    prog(4'h0, 16'h0000, 16'h0100, 8'h44);
    prog(4'h2, 16'h0010, 16'h0000, 8'h48);
    ahb(1'b1, 32'h80, 32'h05);
    xfer(0, 24'h000000, 1'b1, 6'b011111);
    xfer(2, 24'h000010, 1'b1, 6'b100101);
    // block mode, decrementing, two bytes in one burst
    prog(4'h0, 16'h0100, 16'h0000, 8'hA4);
    ahb(1'b1, 32'h04, 32'h1);
    ahb(1'b1, 32'h80, 32'h01);
    xfer(0, 24'h000100, 1'b1, 6'b011010);
    rdchk("cur0", 32'h00, 32'h00FE);
    rdchk("cnt0", 32'h04, 32'hFFFF);
    // cascaded isa master owns the bus, no strobes of ours
    pulse(8'h10);
    for (i = 0; i < 50 && dack === 8'h00; i++) @(negedge hclk);
    chk("casc dack", 32'(dack), 32'h10);
    chk("casc strobes", 32'(strobes), 32'h3F);
    chk("casc master", 32'(master_mode), 32'h1);
    for (i = 0; i < 50 && dack !== 8'h00; i++) @(negedge hclk);
    repeat (2) @(negedge hclk);
    chk("slave mode", 32'(master_mode), 32'h0);
    // refresh cycle from a preset refresh address
    ahb(1'b1, 32'h8C, 32'h1234);
    @(posedge hclk);
    refresh_req <= 1'b1;
    for (i = 0; i < 50 && aen !== 1'b1; i++) @(negedge hclk);
    repeat (2) @(negedge hclk);
    chk("rfsh strobes", 32'(strobes), 32'h35);
    chk("rfsh dack", 32'(dack), 32'h0);
    chk("rfsh addr pins", 32'(dma_addr), 32'h001234);
    @(posedge hclk);
    refresh_req <= 1'b0;
    for (i = 0; i < 50 && aen !== 1'b0; i++) @(negedge hclk);
    rdchk("rfsh addr", 32'h8C, 32'h1235);
    finish_test();
  end
endmodule : tb_top
